// ---- hdl/upo_pkg.sv ----
//------------------------------------------------------------
// Function
// R1: The 16 output data lines always show the output buffer register.
// R2: While system clear is asserted the output buffer register and lines are zero.
// R3: Any write to either or both bytes of the output buffer emits one output-loaded pulse.
// R4: The output-loaded pulse rises with the write and lasts about 400 ns.
// R5: The external device samples output data on the trailing edge of the output-loaded pulse.
// R6: The low-byte-loaded pulse fires only on low byte writes, timed like output-loaded.
// R7: The high-byte-loaded pulse fires only on high byte writes, timed like output-loaded.
// R8: A host read of the input buffer register emits one input-taken pulse.
// R9: The input-taken pulse rises with the read and lasts about 400 ns.
// R10: The external device holds input data until the trailing edge of input-taken.
// R11: Two user command outputs follow control status bits 0 and 1, cleared by system clear.
// R12: The host can write and read back both user command bits.
// R13: System clear is asserted whenever the host bus is initialised.
// R14: A read of the input buffer register returns the current 16 input data lines.
// R15: Strobe widths are parameters in clock cycles defaulting to about 400 ns.
//------------------------------------------------------------
package upo_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned STROBE_NS     = 400;
  localparam int unsigned STROBE_CYC    = (STROBE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W         = 8;

  // Register word offsets
  localparam logic [1:0] CSR_ADDR   = 2'h0;
  localparam logic [1:0] OUTB_ADDR  = 2'h1;
  localparam logic [1:0] INB_ADDR   = 2'h2;

  localparam logic [15:0] ZERO_W    = 16'h0000;
  localparam logic [1:0]  BE_LO     = 2'h1;
  localparam logic [1:0]  BE_HI     = 2'h2;

  // Host register request
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        wr;
    logic        rd;
  } upo_req_t;

  // Strobe bundle toward the external device
  typedef struct packed {
    logic loaded;
    logic lo;
    logic hi;
    logic taken;
  } upo_strb_t;
endpackage

// ---- hdl/upo_port.sv ----
`timescale 1ns/1ps
module upo_port #(
  parameter int unsigned STROBE_CYCLES = upo_pkg::STROBE_CYC
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // Host bus initialise request
  input  wire logic              bus_init_i,
  // Register port
  input  wire upo_pkg::upo_req_t req_i,
  output logic [15:0]            rdata_o,
  // External device side
  input  wire logic [15:0]       input_data_lines_i,
  output logic [15:0]            output_data_lines_o,
  output upo_pkg::upo_strb_t     strb_o,
  output logic [1:0]             user_cmd_o,
  output logic                   sys_clear_o
);

  //----------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------
  logic [15:0] in_s1_q, in_s2_q;
  logic        init_s1_q, init_s2_q;

  // Pins come from another domain; two flops before use
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      in_s1_q   <= upo_pkg::ZERO_W;
      in_s2_q   <= upo_pkg::ZERO_W;
      init_s1_q <= 1'b0;
      init_s2_q <= 1'b0;
    end else begin
      in_s1_q   <= input_data_lines_i;
      in_s2_q   <= in_s1_q;
      init_s1_q <= bus_init_i;
      init_s2_q <= init_s1_q;
    end
  end

  //----------------------------------------------------------
  // Registers
  //----------------------------------------------------------
  logic [15:0] outbuf_q, outbuf_d;
  logic [1:0]  cmd_q, cmd_d;
  logic [15:0] rdata_q, rdata_d;
  logic        clr_q, clr_d;
  logic        wr_out, wr_lo, wr_hi, rd_in;

  // Decode and next state; clear dominates any write in the same cycle
  always_comb begin
    clr_d   = init_s2_q;                                   // see R13
    wr_out  = req_i.wr && (req_i.addr == upo_pkg::OUTB_ADDR);
    wr_lo   = wr_out && req_i.be[0];
    wr_hi   = wr_out && req_i.be[1];
    rd_in   = req_i.rd && (req_i.addr == upo_pkg::INB_ADDR);
    outbuf_d = outbuf_q;
    cmd_d    = cmd_q;
    rdata_d  = upo_pkg::ZERO_W;
    if (wr_lo) begin
      outbuf_d[7:0] = req_i.wdata[7:0];                    // see R1
    end
    if (wr_hi) begin
      outbuf_d[15:8] = req_i.wdata[15:8];
    end
    if (req_i.wr && (req_i.addr == upo_pkg::CSR_ADDR) && req_i.be[0]) begin
      cmd_d = req_i.wdata[1:0];                            // see R12
    end
    if (clr_d || clr_q) begin
      outbuf_d = upo_pkg::ZERO_W;                          // see R2
      cmd_d    = 2'h0;                                     // see R11
    end
    if (req_i.rd) begin
      if (req_i.addr == upo_pkg::CSR_ADDR) begin
        rdata_d = {14'h0000, cmd_q};                       // see R12
      end else if (req_i.addr == upo_pkg::OUTB_ADDR) begin
        rdata_d = outbuf_q;
      end else if (req_i.addr == upo_pkg::INB_ADDR) begin
        rdata_d = in_s2_q;                                 // see R14
      end else begin
        rdata_d = upo_pkg::ZERO_W;
      end
    end
  end

  // Register stage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      outbuf_q <= upo_pkg::ZERO_W;
      cmd_q    <= 2'h0;
      rdata_q  <= upo_pkg::ZERO_W;
      clr_q    <= 1'b0;
    end else begin
      outbuf_q <= outbuf_d;
      cmd_q    <= cmd_d;
      rdata_q  <= rdata_d;
      clr_q    <= clr_d;
    end
  end

  //----------------------------------------------------------
  // Strobe timers
  //----------------------------------------------------------
  // One counter per strobe; a new trigger restarts the width, so a
  // back-to-back access stretches rather than splits the pulse.
  localparam logic [upo_pkg::CNT_W-1:0] WIDTH = STROBE_CYCLES[upo_pkg::CNT_W-1:0];
  logic [3:0] trig;
  logic [3:0] strb_q;
  assign trig = {wr_out, wr_lo, wr_hi, rd_in};             // see R3

  for (genvar g = 0; g < 4; g++) begin : g_strb
    logic [upo_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic                      on_d;
    // Width counter: rises the cycle after the access
    always_comb begin
      cnt_d = cnt_q;
      if (trig[g]) begin
        cnt_d = WIDTH;                                     // see R4
      end else if (cnt_q != '0) begin
        cnt_d = cnt_q - 1'b1;                              // see R15
      end
      on_d = (cnt_d != '0);
    end
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        cnt_q     <= '0;
        strb_q[g] <= 1'b0;
      end else begin
        cnt_q     <= cnt_d;
        strb_q[g] <= on_d;
      end
    end
  end

  // Outputs straight from flops
  assign strb_o.loaded       = strb_q[3];                  // see R3
  assign strb_o.lo           = strb_q[2];                  // see R6
  assign strb_o.hi           = strb_q[1];                  // see R7
  assign strb_o.taken        = strb_q[0];                  // see R8 R9
  assign output_data_lines_o = outbuf_q;                   // see R1
  assign user_cmd_o          = cmd_q;                      // see R11
  assign sys_clear_o         = clr_q;
  assign rdata_o             = rdata_q;

  //----------------------------------------------------------
  // Assertions
  //----------------------------------------------------------
  // All checks share the core clock; reset masks them while it stands
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  //----------------------------------------------------------
  // Checker helpers
  //----------------------------------------------------------
  // Age counters: cycles since the last trigger, saturating so that a
  // long idle spell never wraps round into a false width reading
  logic [upo_pkg::CNT_W-1:0] ld_age_q, ld_age_d;
  logic [upo_pkg::CNT_W-1:0] tk_age_q, tk_age_d;

  // Next age values
  always_comb begin
    ld_age_d = ld_age_q;
    tk_age_d = tk_age_q;
    if (wr_out) begin
      ld_age_d = '0;
    end else if (ld_age_q != '1) begin
      ld_age_d = ld_age_q + 1'b1;
    end
    if (rd_in) begin
      tk_age_d = '0;
    end else if (tk_age_q != '1) begin
      tk_age_d = tk_age_q + 1'b1;
    end
  end

  // Age registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ld_age_q <= '0;
      tk_age_q <= '0;
    end else begin
      ld_age_q <= ld_age_d;
      tk_age_q <= tk_age_d;
    end
  end

  //----------------------------------------------------------
  // Output data and clear
  //----------------------------------------------------------
  // Loads only count when no clear is pending, since clear wins
  data_follows_a: assert property (wr_lo && !clr_d && !clr_q // see R1
      |=> output_data_lines_o[7:0] == $past(req_i.wdata[7:0]))
    else $error("output low byte not loaded");
  hi_follows_a: assert property (wr_hi && !clr_d && !clr_q // see R1
      |=> output_data_lines_o[15:8] == $past(req_i.wdata[15:8]))
    else $error("output high byte not loaded");
  out_hold_a: assert property (!wr_out && !clr_d && !clr_q // see R1
      |=> $stable(output_data_lines_o))
    else $error("output data moved without a write");

  // Clear must hold the lines at zero from the first synced cycle
  clear_zero_a: assert property (clr_q |=> output_data_lines_o == 16'h0000) // see R2
    else $error("outputs not cleared");
  clear_input_a: assert property (clr_d |=> output_data_lines_o == upo_pkg::ZERO_W) // see R2
    else $error("outputs not cleared at init");
  out_read_a: assert property (req_i.rd && req_i.addr == upo_pkg::OUTB_ADDR // see R1
      |=> rdata_o == $past(outbuf_q))
    else $error("output buffer read back wrong");

  //----------------------------------------------------------
  // Strobes
  //----------------------------------------------------------
  // Rise one cycle after the access, stay up for the whole width,
  // and drop exactly WIDTH cycles after the most recent trigger
  load_pulse_a: assert property (wr_out |=> strb_o.loaded) // see R3
    else $error("loaded strobe missing");
  pulse_width_a: assert property (wr_out ##1 !wr_out [*8] |=> strb_o.loaded) // see R4
    else $error("loaded strobe too short");
  loaded_src_a: assert property ($rose(strb_o.loaded) |-> $past(wr_out)) // see R3
    else $error("loaded strobe without a write");
  loaded_fall_a: assert property ($fell(strb_o.loaded) |-> ld_age_q == WIDTH) // see R4 R15
    else $error("loaded strobe width wrong");
  both_bytes_a: assert property (wr_lo && wr_hi |=> strb_o.lo && strb_o.hi) // see R3
    else $error("word write missed a byte strobe");

  // Byte strobes mirror the loaded strobe's timing
  lo_pulse_a: assert property (wr_lo |=> strb_o.lo) // see R6
    else $error("low strobe missing");
  hi_pulse_a: assert property (wr_hi |=> strb_o.hi) // see R7
    else $error("high strobe missing");
  lo_width_a: assert property (wr_lo ##1 !wr_lo [*8] |=> strb_o.lo) // see R6
    else $error("low strobe too short");
  hi_width_a: assert property (wr_hi ##1 !wr_hi [*8] |=> strb_o.hi) // see R7
    else $error("high strobe too short");
  lo_only_a: assert property ($rose(strb_o.lo) |-> $past(wr_lo)) // see R6
    else $error("low strobe without low write");
  hi_only_a: assert property ($rose(strb_o.hi) |-> $past(wr_hi)) // see R7
    else $error("high strobe without high write");

  // Input-taken side follows the same width rules as the loads
  taken_pulse_a: assert property (rd_in |=> strb_o.taken) // see R8 R9
    else $error("taken strobe missing");
  taken_width_a: assert property (rd_in ##1 !rd_in [*8] |=> strb_o.taken) // see R9
    else $error("taken strobe too short");
  taken_src_a: assert property ($rose(strb_o.taken) |-> $past(rd_in)) // see R8
    else $error("taken strobe without a read");
  taken_fall_a: assert property ($fell(strb_o.taken) |-> tk_age_q == WIDTH) // see R9 R15
    else $error("taken strobe width wrong");

  //----------------------------------------------------------
  // Command bits, reads and system clear
  //----------------------------------------------------------
  // Command bits take byte-zero writes unless a clear is pending
  cmd_write_a: assert property (req_i.wr && req_i.addr == upo_pkg::CSR_ADDR // see R11
      && req_i.be[0] && !clr_d && !clr_q |=> user_cmd_o == $past(req_i.wdata[1:0]))
    else $error("command bits not written");
  cmd_hold_a: assert property (!req_i.wr && !clr_d && !clr_q // see R11
      |=> $stable(user_cmd_o))
    else $error("command bits moved without a write");
  cmd_clear_a: assert property (clr_q |=> user_cmd_o == 2'h0) // see R11
    else $error("command bits not cleared");
  cmd_clear_in_a: assert property (clr_d |=> user_cmd_o == 2'h0) // see R11
    else $error("command bits not cleared at init");
  cmd_read_a: assert property (req_i.rd && req_i.addr == upo_pkg::CSR_ADDR // see R12
      |=> rdata_o == {14'h0000, $past(cmd_q)})
    else $error("command bits read back wrong");

  // Read data stands for one cycle only and is zero elsewhere
  in_read_a: assert property (rd_in |=> rdata_o == $past(in_s2_q)) // see R14
    else $error("input read data wrong");
  idle_read_a: assert property (!req_i.rd |=> rdata_o == upo_pkg::ZERO_W) // see R14
    else $error("read data outside a read");
  unmapped_read_a: assert property (req_i.rd && req_i.addr != upo_pkg::CSR_ADDR // see R14
      && req_i.addr != upo_pkg::OUTB_ADDR && req_i.addr != upo_pkg::INB_ADDR
      |=> rdata_o == upo_pkg::ZERO_W)
    else $error("unmapped read not zero");

  // Three sampled cycles of init cover both synchroniser stages
  init_clear_a: assert property (bus_init_i [*3] |=> sys_clear_o) // see R13
    else $error("system clear late");
  clear_follow_a: assert property (sys_clear_o == $past(init_s2_q)) // see R13
    else $error("system clear out of step with init");

  //----------------------------------------------------------
  // Coverage
  //----------------------------------------------------------
  // Main scenarios the bench should reach
  write_cov: cover property (wr_lo && wr_hi);
  read_cov: cover property (rd_in);
  clear_cov: cover property (clr_q && wr_out);
  hi_cov: cover property (wr_hi && !wr_lo);
  taken_end_cov: cover property ($fell(strb_o.taken));
endmodule // upo_port

// ---- dv/upo_far_dev.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// Far-side device logic
// ---------------------------------------------
module upo_far_dev (
  // Clock
  input  wire logic               clock_i,
  // From the port
  input  wire logic [15:0]        output_data_lines_i,
  input  wire upo_pkg::upo_strb_t strb_i,
  // To the port and the bench
  output logic [15:0]             input_data_lines_o = 16'h3C5A,
  output logic [15:0]             captured_o = 16'h0000
);
  logic loaded_q = 1'b0;
  logic taken_q  = 1'b0;
  // Latch only on trailing edges; leading-edge data may still be settling
  always_ff @(posedge clock_i) begin
    loaded_q <= strb_i.loaded;
    taken_q  <= strb_i.taken;
    if (loaded_q && !strb_i.loaded) captured_o <= output_data_lines_i;
    // Input is held until the read strobe ends, then rotates left one bit and XORs with 16'hA5C3
    if (taken_q && !strb_i.taken)
      input_data_lines_o <= {input_data_lines_o[14:0], input_data_lines_o[15]} ^ 16'hA5C3;
  end
endmodule // upo_far_dev

// ---- dv/tb_user_port_output_signalling.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// Bench for the output signalling port
// ---------------------------------------------
module tb_user_port_output_signalling;
  localparam int unsigned SC = 10; // Short strobe keeps the run brief
  logic               clock_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               bus_init_i = 1'b0;
  upo_pkg::upo_req_t  req = '0;
  upo_pkg::upo_strb_t strb;
  logic [15:0]        rdata, outl, inl, capt, r, d, e_in;
  logic [15:0]        m_out = 16'h0000;
  logic [1:0]         m_cmd = 2'h0;
  logic [1:0]         cmd, be;
  logic               sclr;
  int                 miscompares = 0;
  int                 checks_done = 0;
  int                 seed = 32'hDB65;

  always #2 clock_i = ~clock_i;

  upo_port #(.STROBE_CYCLES(SC)) uut (.clock_i(clock_i), .rst_i(rst_i), .bus_init_i(bus_init_i),
    .req_i(req), .rdata_o(rdata), .input_data_lines_i(inl), .output_data_lines_o(outl),
    .strb_o(strb), .user_cmd_o(cmd), .sys_clear_o(sclr));
  upo_far_dev far (.clock_i(clock_i), .output_data_lines_i(outl), .strb_i(strb),
    .input_data_lines_o(inl), .captured_o(capt));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle access; read data is taken in the cycle after the request
  task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] wd,
                     input logic [1:0] b, output logic [15:0] rd);
    @(posedge clock_i);
    req <= '{addr: a, wdata: wd, be: b, wr: w, rd: !w};
    @(posedge clock_i);
    req <= '0;
    #1 rd = rdata;
  endtask

  // Strobes rise at once, stand SC cycles, then drop
  task automatic pulse(input logic [3:0] e);
    chk({12'h000, strb}, {12'h000, e});
    repeat (SC - 1) @(posedge clock_i);
    #1 chk({12'h000, strb}, {12'h000, e});
    @(posedge clock_i);
    #1 chk({12'h000, strb}, 16'h0000);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #20000;
    miscompares++;
    summarize;
  end

  // Main sequence: byte enables cycle through low, high, both
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      be = 2'(i % 3 + 1);
      if (be[0]) m_out[7:0] = d[7:0];
      if (be[1]) m_out[15:8] = d[15:8];
      acc(1'b1, upo_pkg::OUTB_ADDR, d, be, r);
      pulse({1'b1, be[0], be[1], 1'b0});
      chk(outl, m_out);
      @(posedge clock_i);
      #1 chk(capt, m_out);
      acc(1'b0, upo_pkg::OUTB_ADDR, 16'h0000, 2'h0, r);
      chk(r, m_out);
      m_cmd = d[9:8];
      acc(1'b1, upo_pkg::CSR_ADDR, {14'h0000, m_cmd}, 2'h3, r);
      chk({14'h0000, cmd}, {14'h0000, m_cmd});
      acc(1'b0, upo_pkg::CSR_ADDR, 16'h0000, 2'h0, r);
      chk({14'h0000, r[1:0]}, {14'h0000, m_cmd});
      e_in = inl;
      acc(1'b0, upo_pkg::INB_ADDR, 16'h0000, 2'h0, r);
      chk(r, e_in);
      pulse(4'h1);
      acc(1'b0, 2'h3, 16'h0000, 2'h0, r);
      chk(r, 16'h0000);
    end
    // Bus initialise clears the output lines and command bits; writes during it stay zero though strobes still fire
    @(posedge clock_i);
    bus_init_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1 chk({13'h0000, sclr, cmd}, 16'h0004);
    chk(outl, 16'h0000);
    acc(1'b1, upo_pkg::OUTB_ADDR, 16'hFFFF, 2'h3, r);
    pulse(4'hE);
    chk(outl, 16'h0000);
    @(posedge clock_i);
    bus_init_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    #1 chk({15'h0000, sclr}, 16'h0000);
    summarize;
  end
endmodule // tb_user_port_output_signalling
